/* File: tocc_pkg.sv */
// Constants and types shared by the timer output and capture control block.
package tocc_pkg;
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 16;

   // Register offsets.
   localparam logic [2:0] OFS_MODE   = 3'h0;
   localparam logic [2:0] OFS_OUT    = 3'h1;
   localparam logic [2:0] OFS_CAP    = 3'h2;
   localparam logic [2:0] OFS_PRESC  = 3'h3;
   localparam logic [2:0] OFS_CCA    = 3'h4;
   localparam logic [2:0] OFS_CCB    = 3'h5;
   localparam logic [2:0] OFS_COUNT  = 3'h6;
   localparam logic [2:0] OFS_STATUS = 3'h7;

   // Field positions.
   localparam int unsigned RUN_LO     = 2;
   localparam int unsigned RUN_HI     = 3;
   localparam int unsigned OUT_EN     = 0;
   localparam int unsigned TOG_A      = 1;
   localparam int unsigned PRE_LOW    = 2;
   localparam int unsigned PRE_HIGH   = 3;
   localparam int unsigned TOG_B      = 4;
   localparam int unsigned ONESHOT    = 5;
   localparam int unsigned SW_TRIG    = 6;
   localparam int unsigned CAP_A_EN   = 0;
   localparam int unsigned CAP_A_REV  = 1;
   localparam int unsigned CAP_B_EN   = 2;
   localparam int unsigned PSEL_LO    = 0;
   localparam int unsigned PSEL_HI    = 1;
   localparam int unsigned EDGE_LO    = 4;
   localparam int unsigned EDGE_HI    = 5;

   localparam logic [15:0] ZERO16     = 16'h0000;
   localparam logic [15:0] ONE16      = 16'h0001;
   localparam logic [7:0]  ZERO8      = 8'h00;

   // Run modes held in the two-bit run-mode field.
   typedef enum logic [1:0] {
      RUN_STOP      = 2'b00,
      RUN_FREE      = 2'b01,
      RUN_CLR_EDGE  = 2'b10,
      RUN_CLR_MATCH = 2'b11
   } tocc_run_e;

   // Edge codes of the edge-select field; EDGE_NONE selects no valid edge.
   localparam logic [1:0] EDGE_FALL = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_NONE = 2'b10;
   localparam logic [1:0] EDGE_BOTH = 2'b11;

   // Prescaler divide limits, count clock = sys_clk / (limit + 1).
   localparam logic [5:0] PRESC_LIM0 = 6'h00;
   localparam logic [5:0] PRESC_LIM1 = 6'h03;
   localparam logic [5:0] PRESC_LIM2 = 6'h0F;
   localparam logic [5:0] PRESC_LIM3 = 6'h3F;
endpackage

/* File: tocc_timer16.sv */
// One 16-bit timer channel with compare output, one-shot and capture.
// How it works
// R1 - Nonzero run-mode write starts counting at once; 00 keeps it stopped.
// R2 - Software leaves compare registers alone while running, except B for PPG.
// R3 - Lower B right after B match, raise it right after A match.
// R4 - B change: mask, stop B toggle, write, wait one count, restore.
// R5 - Preset bits: 00 keep, 01 force low, 10 force high, 11 forbidden.
// R6 - Preset bits are written only while stopped.
// R7 - On start the pin begins from the preset level.
// R8 - Square wave: pin inverts on every match A event.
// R9 - PPG needs B strictly below A.
// R10 - One-shot never uses equal compare values.
// R11 - Pulse-width measurement keeps output control at zero.
// R12 - Edge clear mode with input B edges keeps output control zero.
// R13 - First match after start may be off by one count clock.
// R14 - Clear-on-match-A mode needs both compare values nonzero.
// R15 - Capture during a read still happens; the read value is undefined.
// R16 - Capture event fires on valid edge, not on reverse-phase capture.
// R17 - Software reads a capture only after its event.
// R18 - Compare/capture contents are undefined after the counter stops.
// R19 - Edge select is written only while stopped.
// R20 - No new one-shot trigger while the active level is out.
// R21 - Triggers during an active one-shot pulse are ignored; in edge-clear mode the code still clears the counter on a valid A edge.
// R22 - Trigger clears and starts; active at smaller, inactive at larger.
// R23 - Counter and both registers are 16 bits, counted on the count clock.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module tocc_timer16 (
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic [2:0]  addr_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        wr_en_i,
   input  wire logic        rd_en_i,
   output logic      [15:0] rd_data_o,
   input  wire logic        trigger_in_a_i,
   input  wire logic        trigger_in_b_i,
   output logic             timer_out_pin_o,
   output logic             match_a_irq_o,
   output logic             match_b_irq_o
);
   function automatic logic edge_ok(input logic [1:0] sel,
                                    input logic rise, input logic fall);
      edge_ok = (sel == tocc_pkg::EDGE_RISE && rise) ||
                (sel == tocc_pkg::EDGE_FALL && fall) ||
                (sel == tocc_pkg::EDGE_BOTH && (rise || fall));
   endfunction

   logic [15:0] count_value;
   logic [15:0] compare_capture_a;
   logic [15:0] compare_capture_b;
   logic [15:0] next_count;
   logic [7:0]  timer_mode_ctrl;
   logic [7:0]  output_ctrl;
   logic [7:0]  cap_ctrl;
   logic [7:0]  prescaler_mode;
   logic [5:0]  presc_cnt;
   logic [5:0]  presc_lim;
   logic        trig_a_q;
   logic        trig_b_q;
   logic        out_level;
   logic        next_level;
   logic        os_active;
   tocc_pkg::tocc_run_e run_mode;

   wire [1:0] edge_sel  = {prescaler_mode[tocc_pkg::EDGE_HI],
                           prescaler_mode[tocc_pkg::EDGE_LO]};
   wire [1:0] psel      = {prescaler_mode[tocc_pkg::PSEL_HI],
                           prescaler_mode[tocc_pkg::PSEL_LO]};
   wire       running   = run_mode != tocc_pkg::RUN_STOP;
   wire       wr_mode   = wr_en_i && addr_i == tocc_pkg::OFS_MODE;
   wire [1:0] wr_run    = {wr_data_i[tocc_pkg::RUN_HI],
                           wr_data_i[tocc_pkg::RUN_LO]};
   wire       start     = wr_mode && !running &&
                          wr_run != tocc_pkg::RUN_STOP;
   wire       count_tick = running && presc_cnt == presc_lim;
   wire       cap_a_en  = cap_ctrl[tocc_pkg::CAP_A_EN];
   wire       cap_b_en  = cap_ctrl[tocc_pkg::CAP_B_EN];
   wire       oneshot   = output_ctrl[tocc_pkg::ONESHOT];

   // Input edges are only seen while the timer runs.
   wire a_rise  = trigger_in_a_i && !trig_a_q;
   wire a_fall  = !trigger_in_a_i && trig_a_q;
   wire b_rise  = trigger_in_b_i && !trig_b_q;
   wire b_fall  = !trigger_in_b_i && trig_b_q;
   wire valid_a = running && edge_ok(edge_sel, a_rise, a_fall);
   wire valid_b = running && edge_ok(edge_sel, b_rise, b_fall);
   wire rev_a   = running && cap_ctrl[tocc_pkg::CAP_A_REV] &&
                  ((edge_sel == tocc_pkg::EDGE_RISE && a_fall) ||
                   (edge_sel == tocc_pkg::EDGE_FALL && a_rise));

   wire match_a = count_tick && !cap_a_en && count_value == compare_capture_a;
   wire match_b = count_tick && !cap_b_en && count_value == compare_capture_b;
   wire b_first = compare_capture_b < compare_capture_a;
   wire match_lo = b_first ? match_b : match_a;
   wire match_hi = b_first ? match_a : match_b;

   // A one-shot trigger is taken only when no pulse is under way.
   wire sw_trig = wr_en_i && addr_i == tocc_pkg::OFS_OUT &&
                  wr_data_i[tocc_pkg::SW_TRIG];
   wire os_trig = running && oneshot && !os_active &&       // [R21]
                  run_mode != tocc_pkg::RUN_CLR_MATCH &&
                  (sw_trig || valid_a);
   wire cnt_clear = start || os_trig ||                     // [R22]
                    (run_mode == tocc_pkg::RUN_CLR_EDGE && valid_a) ||
                    (run_mode == tocc_pkg::RUN_CLR_MATCH && match_a);

   wire cap_a_ev = running && cap_a_en && (valid_a || rev_a);
   wire cap_b_ev = running && cap_b_en && valid_b;
   wire irq_a    = match_a || (running && cap_a_en && valid_a); // [R16]
   wire irq_b    = match_b || cap_b_ev;

   always_comb begin
      case (psel)
         2'b00:   presc_lim = tocc_pkg::PRESC_LIM0;
         2'b01:   presc_lim = tocc_pkg::PRESC_LIM1;
         2'b10:   presc_lim = tocc_pkg::PRESC_LIM2;
         default: presc_lim = tocc_pkg::PRESC_LIM3;
      endcase
   end

   // Counting begins on the write itself, so the first tick comes up to one
   // count clock late relative to a free-running prescaler.
   always_comb begin
      if (!running && !start) begin
         next_count = tocc_pkg::ZERO16;                     // [R1]
      end else if (cnt_clear) begin
         next_count = tocc_pkg::ZERO16;                     // [R1] [R13]
      end else if (count_tick) begin
         next_count = 16'(count_value + tocc_pkg::ONE16);   // [R23]
      end else begin
         next_count = count_value;
      end
   end

   // Output level; the preset only acts while stopped and is kept at start.
   always_comb begin
      next_level = out_level;                               // [R7]
      if (!running) begin
         if (output_ctrl[tocc_pkg::PRE_HIGH] &&
             !output_ctrl[tocc_pkg::PRE_LOW]) begin
            next_level = 1'b1;                              // [R5]
         end else if (output_ctrl[tocc_pkg::PRE_LOW] &&
                      !output_ctrl[tocc_pkg::PRE_HIGH]) begin
            next_level = 1'b0;                              // [R5]
         end
      end else if (oneshot) begin
         if (os_active && match_hi) begin
            next_level = 1'b0;                              // [R22]
         end else if (os_active && match_lo) begin
            next_level = 1'b1;                              // [R22]
         end
      end else begin
         next_level = out_level ^
            (match_a && output_ctrl[tocc_pkg::TOG_A]) ^     // [R8]
            (match_b && output_ctrl[tocc_pkg::TOG_B]);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         timer_mode_ctrl <= tocc_pkg::ZERO8;
         output_ctrl     <= tocc_pkg::ZERO8;
         cap_ctrl        <= tocc_pkg::ZERO8;
         prescaler_mode  <= tocc_pkg::ZERO8;
      end else if (wr_en_i) begin
         if (addr_i == tocc_pkg::OFS_MODE) begin
            timer_mode_ctrl <= wr_data_i[7:0];
         end else if (addr_i == tocc_pkg::OFS_OUT) begin
            output_ctrl <= {1'b0, wr_data_i[6:0]} &
                           ~(8'h01 << tocc_pkg::SW_TRIG);
         end else if (addr_i == tocc_pkg::OFS_CAP) begin
            cap_ctrl <= wr_data_i[7:0];
         end else if (addr_i == tocc_pkg::OFS_PRESC) begin
            prescaler_mode <= wr_data_i[7:0];
         end
      end
   end

   assign run_mode = tocc_pkg::tocc_run_e'(
      {timer_mode_ctrl[tocc_pkg::RUN_HI], timer_mode_ctrl[tocc_pkg::RUN_LO]});

   // A capture wins over a software write in the same cycle; a read that
   // meets a capture returns the value held before the capture. After a stop both
   // registers simply hold, and software must not trust them.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         compare_capture_a <= tocc_pkg::ZERO16;
         compare_capture_b <= tocc_pkg::ZERO16;
      end else begin
         if (cap_a_ev) begin
            compare_capture_a <= count_value;               // [R15] [R18]
         end else if (wr_en_i && addr_i == tocc_pkg::OFS_CCA) begin
            compare_capture_a <= wr_data_i;
         end
         if (cap_b_ev) begin
            compare_capture_b <= count_value;               // [R15]
         end else if (wr_en_i && addr_i == tocc_pkg::OFS_CCB) begin
            compare_capture_b <= wr_data_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         count_value     <= tocc_pkg::ZERO16;
         presc_cnt       <= 6'h00;
         trig_a_q        <= 1'b0;
         trig_b_q        <= 1'b0;
         out_level       <= 1'b0;
         os_active       <= 1'b0;
         timer_out_pin_o <= 1'b0;
         match_a_irq_o   <= 1'b0;
         match_b_irq_o   <= 1'b0;
      end else begin
         count_value     <= next_count;
         presc_cnt       <= (!running || count_tick) ? 6'h00 :
                            6'(presc_cnt + 6'h01);
         trig_a_q        <= trigger_in_a_i;
         trig_b_q        <= trigger_in_b_i;
         out_level       <= next_level;
         os_active       <= running && (os_trig || (os_active && !match_hi));
         timer_out_pin_o <= output_ctrl[tocc_pkg::OUT_EN] && next_level;
         match_a_irq_o   <= irq_a;
         match_b_irq_o   <= irq_b;
      end
   end

   logic [15:0] rd_mux;
   always_comb begin
      if (addr_i == tocc_pkg::OFS_MODE) begin
         rd_mux = {8'h00, timer_mode_ctrl};
      end else if (addr_i == tocc_pkg::OFS_OUT) begin
         rd_mux = {8'h00, output_ctrl};
      end else if (addr_i == tocc_pkg::OFS_CAP) begin
         rd_mux = {8'h00, cap_ctrl};
      end else if (addr_i == tocc_pkg::OFS_PRESC) begin
         rd_mux = {8'h00, prescaler_mode};
      end else if (addr_i == tocc_pkg::OFS_CCA) begin
         rd_mux = compare_capture_a;
      end else if (addr_i == tocc_pkg::OFS_CCB) begin
         rd_mux = compare_capture_b;
      end else if (addr_i == tocc_pkg::OFS_COUNT) begin
         rd_mux = count_value;
      end else begin
         rd_mux = {13'h0000, os_active, out_level, running};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rd_data_o <= tocc_pkg::ZERO16;
      end else begin
         rd_data_o <= rd_en_i ? rd_mux : tocc_pkg::ZERO16;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   sequence start_seq;
      start ##1 running;
   endsequence

   start_clear_a: assert property (start_seq |->                   // [R1]
      count_value == 16'h0000)
      else $error("Counter not zero after start.");
   stop_hold_a: assert property (!running && !start |=>           // [R1]
      count_value == 16'h0000)
      else $error("Counter moves while stopped.");
   preset_level_a: assert property (!running && !start &&              // [R5]
      output_ctrl[tocc_pkg::PRE_HIGH] != output_ctrl[tocc_pkg::PRE_LOW]
      |=> out_level == $past(output_ctrl[tocc_pkg::PRE_HIGH]))
      else $error("Preset level not applied.");
   start_level_a: assert property (start |=> out_level ==         // [R7]
      ($past(output_ctrl[tocc_pkg::PRE_HIGH] ^
             output_ctrl[tocc_pkg::PRE_LOW]) ?
       $past(output_ctrl[tocc_pkg::PRE_HIGH]) : $past(out_level)))
      else $error("Output level at start differs from the preset.");
   square_toggle_a: assert property (running && !oneshot && match_a && // [R8]
      output_ctrl[tocc_pkg::TOG_A] && !match_b |=>
      out_level != $past(out_level))
      else $error("Output did not invert on match A.");
   capture_irq_a: assert property (running && cap_a_en && valid_a |=> // [R16]
      match_a_irq_o && compare_capture_a == $past(count_value))
      else $error("Capture or its event missing.");
   reverse_noirq_a: assert property (rev_a && !count_tick &&      // [R16]
      cap_a_en |=> !match_a_irq_o)
      else $error("Event raised on reverse-phase capture.");
   oneshot_ignore_a: assert property (os_active && valid_a &&     // [R21]
      !match_hi && run_mode == tocc_pkg::RUN_FREE |=>
      count_value != 16'h0000 || $past(count_value) == 16'hFFFF)
      else $error("Trigger restarted an active pulse.");
   oneshot_start_a: assert property (os_trig |=> os_active &&         // [R22]
      count_value == 16'h0000)
      else $error("One-shot trigger did not clear and start.");
   tick_width_a: assert property (count_tick && !cnt_clear |=>         // [R23]
      count_value == 16'($past(count_value) + 16'h0001))
      else $error("Counter step wrong.");
endmodule

/* File: tocc_trig_src.sv */
// Behavioural model of the trigger sources on the two timer input pins.
`timescale 1ns/100ps
module tocc_trig_src (
   input  wire logic sys_clk_i,
   input  wire logic active_i,
   output logic      trig_a_o,
   output logic      trig_b_o
);
   initial begin
      trig_a_o = 1'b0;
      trig_b_o = 1'b0;
   end

   // A polite source holds off while the pulse is active; force_it breaks that.
   task automatic set_a(input logic lvl, input logic force_it);
      @(posedge sys_clk_i);
      if (active_i !== 1'b1 || force_it) begin
         trig_a_o <= lvl;
      end
   endtask

   task automatic set_b(input logic lvl);
      @(posedge sys_clk_i);
      trig_b_o <= lvl;
   endtask
endmodule

/* File: tocc_timer16_tb.sv */
// Self-checking testbench for the timer output and capture channel.
`timescale 1ns/100ps
module tocc_timer16_tb;
   typedef struct packed {
      logic [2:0]  addr;
      logic [15:0] wdat;
      logic [15:0] rexp;
   } tocc_row_s;
   logic        sys_clk_i = 1'b0;
   logic        srst_i    = 1'b1;
   logic [2:0]  addr_i    = 3'h0;
   logic [15:0] wr_data_i = 16'h0000;
   logic        wr_en_i   = 1'b0;
   logic        rd_en_i   = 1'b0;
   logic [15:0] rd_data_o;
   logic        trigger_in_a_i;
   logic        trigger_in_b_i;
   logic        timer_out_pin_o;
   logic        match_a_irq_o;
   logic        match_b_irq_o;
   int          bad_count = 0;
   int          n_checks  = 0;
   int          n;
   tocc_row_s   rows [7];
   logic [15:0] v0;
   logic [15:0] v1;
   logic        lv [3];
   logic [7:0]  pv [6] = '{8'h09, 8'h05, 8'h01, 8'h0D, 8'h09, 8'h03};
   logic        pe [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

   always #5 sys_clk_i = ~sys_clk_i;

   tocc_timer16 u_tocc_timer16 (
      .sys_clk_i       (sys_clk_i),
      .srst_i          (srst_i),
      .addr_i          (addr_i),
      .wr_data_i       (wr_data_i),
      .wr_en_i         (wr_en_i),
      .rd_en_i         (rd_en_i),
      .rd_data_o       (rd_data_o),
      .trigger_in_a_i  (trigger_in_a_i),
      .trigger_in_b_i  (trigger_in_b_i),
      .timer_out_pin_o (timer_out_pin_o),
      .match_a_irq_o   (match_a_irq_o),
      .match_b_irq_o   (match_b_irq_o)
   );

   tocc_trig_src u_tocc_trig_src (
      .sys_clk_i (sys_clk_i),
      .active_i  (timer_out_pin_o),
      .trig_a_o  (trigger_in_a_i),
      .trig_b_o  (trigger_in_b_i)
   );

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                      input string msg);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
                  seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_en_i   <= 1'b1;
      @(posedge sys_clk_i);
      wr_en_i   <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge sys_clk_i);
      addr_i  <= a;
      rd_en_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_en_i <= 1'b0;
      #1;
      d = rd_data_o;
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         0: return match_a_irq_o;
         1: return match_b_irq_o;
         default: return timer_out_pin_o;
      endcase
   endfunction

   // Polls one output each cycle until it is high or the limit runs out.
   task automatic wait_for(input int sel, input int lim, input logic want,
                           output int cnt);
      cnt = 0;
      do begin
         @(posedge sys_clk_i);
         #1;
         cnt++;
      end while (cnt < lim && sig(sel) !== 1'b1);
      chk({15'h0000, sig(sel)}, {15'h0000, want}, "event presence");
   endtask

   initial begin
      #100000;
      bad_count++;
      stop_test();
   end

   initial begin
      rows = '{'{tocc_pkg::OFS_OUT,    16'h0041, 16'h0001},
               '{tocc_pkg::OFS_CAP,    16'h0005, 16'h0005},
               '{tocc_pkg::OFS_PRESC,  16'h0031, 16'h0031},
               '{tocc_pkg::OFS_CCA,    16'h1234, 16'h1234},
               '{tocc_pkg::OFS_CCB,    16'h00AB, 16'h00AB},
               '{tocc_pkg::OFS_COUNT,  16'hFFFF, 16'h0000},
               '{tocc_pkg::OFS_STATUS, 16'hFFFF, 16'h0000}};
      repeat (9) @(posedge sys_clk_i);
      #1;
      chk(rd_data_o, 16'h0000, "read data in reset");
      chk({13'h0000, timer_out_pin_o, match_a_irq_o, match_b_irq_o},
          16'h0000, "outputs in reset");
      @(posedge sys_clk_i);
      srst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd(i[2:0], v0);
         chk(v0, 16'h0000, "reset value");
      end
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdat);
         rd(rows[i].addr, v0);
         chk(v0, rows[i].rexp, "register readback");
         @(posedge sys_clk_i);
         #1;
         chk(rd_data_o, 16'h0000, "read data after answer");
      end
      wr(tocc_pkg::OFS_CAP, 16'h0000);
      wr(tocc_pkg::OFS_PRESC, 16'h0000);
      // Preset levels while stopped: high, low, keep, forbidden code, high, keep.
      foreach (pv[i]) begin
         wr(tocc_pkg::OFS_OUT, {8'h00, pv[i]});
         repeat (2) @(posedge sys_clk_i);
         #1;
         chk({15'h0000, timer_out_pin_o}, {15'h0000, pe[i]}, "preset");
      end
      wr(tocc_pkg::OFS_CCA, 16'h0002);
      wr(tocc_pkg::OFS_MODE, 16'h000C);
      #1;
      chk({15'h0000, timer_out_pin_o}, 16'h0001, "start level");
      for (int i = 0; i < 3; i++) begin
         wait_for(0, 10, 1'b1, n);
         lv[i] = timer_out_pin_o;
         if (i > 0) begin
            chk(n[15:0], 16'h0003, "square period");
            chk({15'h0000, lv[i]}, {15'h0000, ~lv[i-1]}, "toggle");
         end
      end
      for (int m = 0; m < 4; m++) begin
         wr(tocc_pkg::OFS_MODE, 16'h0000);
         wr(tocc_pkg::OFS_CCA, 16'hFFFF);
         wr(tocc_pkg::OFS_MODE, {12'h000, m[1:0], 2'b00});
         rd(tocc_pkg::OFS_COUNT, v0);
         rd(tocc_pkg::OFS_COUNT, v1);
         chk({15'h0000, v1 !== v0}, {15'h0000, m != 0}, "run mode");
      end
      wr(tocc_pkg::OFS_MODE, 16'h0000);
      wr(tocc_pkg::OFS_OUT, 16'h0000);
      wr(tocc_pkg::OFS_PRESC, 16'h0010);
      wr(tocc_pkg::OFS_CAP, 16'h0007);
      wr(tocc_pkg::OFS_MODE, 16'h0008);
      u_tocc_trig_src.set_a(1'b1, 1'b0);
      wait_for(0, 8, 1'b1, n);
      rd(tocc_pkg::OFS_CCA, v0);
      u_tocc_trig_src.set_a(1'b0, 1'b0);
      wait_for(0, 6, 1'b0, n);
      rd(tocc_pkg::OFS_CCA, v1);
      chk({15'h0000, v1 !== v0}, 16'h0001, "reverse capture");
      u_tocc_trig_src.set_b(1'b1);
      wait_for(1, 8, 1'b1, n);
      wr(tocc_pkg::OFS_MODE, 16'h0000);
      wr(tocc_pkg::OFS_CAP, 16'h0000);
      u_tocc_trig_src.set_a(1'b0, 1'b0);
      wr(tocc_pkg::OFS_CCB, 16'h0004);
      wr(tocc_pkg::OFS_CCA, 16'h0008);
      wr(tocc_pkg::OFS_OUT, 16'h0021);
      wr(tocc_pkg::OFS_MODE, 16'h0004);
      // First pulse from the pin with a forced retrigger, then by software.
      for (int k = 0; k < 2; k++) begin
         if (k == 0) begin
            u_tocc_trig_src.set_a(1'b1, 1'b0);
         end else begin
            wr(tocc_pkg::OFS_OUT, 16'h0061);
         end
         wait_for(2, 30, 1'b1, n);
         n = 1;
         fork
            begin
               if (k == 0) begin
                  u_tocc_trig_src.set_a(1'b0, 1'b1);
                  u_tocc_trig_src.set_a(1'b1, 1'b1);
               end
            end
            while (timer_out_pin_o === 1'b1 && n < 30) begin
               @(posedge sys_clk_i);
               #1;
               if (timer_out_pin_o === 1'b1) n++;
            end
         join
         chk(n[15:0], 16'h0004, "one-shot width");
      end
      // Pulse-generator duty change: B is raised right after an A match.
      wr(tocc_pkg::OFS_MODE, 16'h0000);
      wr(tocc_pkg::OFS_CCA, 16'h0020);
      wr(tocc_pkg::OFS_CCB, 16'h0010);
      wr(tocc_pkg::OFS_OUT, 16'h0013);
      wr(tocc_pkg::OFS_MODE, 16'h000C);
      wait_for(1, 40, 1'b1, n);
      chk(n[15:0], 16'h0011, "first match B");
      wait_for(0, 40, 1'b1, n);
      chk(n[15:0], 16'h0010, "match A after B");
      wr(tocc_pkg::OFS_OUT, 16'h0003);
      wr(tocc_pkg::OFS_CCB, 16'h0018);
      wr(tocc_pkg::OFS_OUT, 16'h0013);
      #1;
      lv[0] = timer_out_pin_o;
      wait_for(1, 40, 1'b1, n);
      chk(n[15:0], 16'h0013, "raised match B");
      chk({15'h0000, timer_out_pin_o}, {15'h0000, ~lv[0]}, "B toggle");
      stop_test();
   end
endmodule
